//--- lcdcd_decoder.sv
`timescale 1ns/1ps
module lcdcd_decoder
    import lcdcd_pkg::*;
#(
    parameter logic [7:0] IDENT_CODE = 8'hA5 // Arbitrary value
)(
    input  wire logic              core_clk_in,
    input  wire logic              srst_in,
    input  wire logic              cmd_we_in,
    input  wire logic              param_we_in,
    input  wire logic              param_re_in,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        rd_data_out,
    output logic                   rd_valid_out,
    output logic      [1:0]        pixel_depth_out,
    output lcdcd_synth_s           synth_out,
    output lcdcd_flags_s           flags_out,
    output lcdcd_timing_s          timing_out,
    output logic                   scroll_sync_flag_out,
    output logic [PAL_ENTRIES*PAL_W-1:0] palette_out,
    output logic                   palette_we_out,
    output logic      [3:0]        palette_idx_out,
    output logic      [7:0]        drive_select_out,
    output logic                   busy_out
);
    // ==========================================================
    // Sequencing
    lcdcd_state_e state_q;
    lcdcd_state_e state_d;
    logic [4:0]   idx_q;
    logic [4:0]   last_idx;
    logic         param_take;
    logic         seq_done;
    logic         id_pending_q;

    assign param_take = param_we_in && (state_q != LCDCD_IDLE);
    assign last_idx   = (state_q == LCDCD_SYNTH)   ? SYNTH_PARAMS - 5'd1 :
                        (state_q == LCDCD_TIMING)  ? TIMING_PARAMS - 5'd1 :
                        (state_q == LCDCD_PALETTE) ? PALETTE_PARAMS - 5'd1 :
                        5'd0;
    assign seq_done   = param_take && (idx_q == last_idx);
    assign busy_out   = (state_q != LCDCD_IDLE);

    always_comb begin
        state_d = state_q;
        if (cmd_we_in) begin
            case (data_in)
                CMD_PIXEL_DEPTH:  state_d = LCDCD_DEPTH;
                CMD_SYNTH:        state_d = LCDCD_SYNTH;
                CMD_PANEL_FLAGS:  state_d = LCDCD_FLAGS;
                CMD_PANEL_TIMING: state_d = LCDCD_TIMING;
                CMD_SCROLL_SYNC:  state_d = LCDCD_SCROLL;
                CMD_PALETTE:      state_d = LCDCD_PALETTE;
                CMD_DRIVE_SELECT: state_d = LCDCD_DRIVE;
                default:          state_d = LCDCD_IDLE;
            endcase
        end else if (seq_done) begin
            state_d = LCDCD_IDLE;
        end
    end

    // A new command byte aborts any half-finished parameter run.
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            state_q <= LCDCD_IDLE;
            idx_q   <= 5'd0;
        end else begin
            state_q <= state_d;
            if (cmd_we_in || seq_done) begin
                idx_q <= 5'd0;
            end else if (param_take) begin
                idx_q <= idx_q + 5'd1;
            end
        end
    end

    // ==========================================================
    // Identification read
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            id_pending_q <= 1'b0;
            rd_data_out  <= 8'h00;
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= 1'b0;
            if (cmd_we_in) begin
                id_pending_q <= (data_in == CMD_IDENT);
            end else if (param_re_in && id_pending_q) begin
                id_pending_q <= 1'b0;
                rd_data_out  <= IDENT_CODE;
                rd_valid_out <= 1'b1;
            end else if (param_we_in) begin
                // Only a read before any parameter write or any command other than 0x61 returns the code
                id_pending_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Single-byte and synthesiser parameters
    logic we_depth, we_synth, we_flags, we_scroll, we_drive;
    assign we_depth  = param_take && (state_q == LCDCD_DEPTH);
    assign we_synth  = param_take && (state_q == LCDCD_SYNTH);
    assign we_flags  = param_take && (state_q == LCDCD_FLAGS);
    assign we_scroll = param_take && (state_q == LCDCD_SCROLL);
    assign we_drive  = param_take && (state_q == LCDCD_DRIVE);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            pixel_depth_out      <= 2'b00;
            synth_out            <= '0;
            flags_out            <= '0;
            scroll_sync_flag_out <= 1'b0;
            drive_select_out     <= DRIVE_RESET;
        end else begin
            if (we_depth) begin
                pixel_depth_out <= data_in[1:0];
            end
            if (we_synth && idx_q == 5'd0) begin
                synth_out.output_divider      <= data_in[7:4];
                synth_out.synth_input_divider <= data_in[3:0];
            end
            if (we_synth && idx_q == 5'd1) begin
                synth_out.synth_range_field <= data_in[7:4];
                synth_out.multiplier        <= data_in[3:0];
            end
            if (we_synth && idx_q == 5'd2) begin
                synth_out.two_bit_field        <= data_in[6:5];
                synth_out.synth_five_bit_field <= data_in[4:0];
            end
            if (we_flags) begin
                flags_out <= {data_in[7:4], data_in[2:0]};
            end
            if (we_scroll) begin
                scroll_sync_flag_out <= data_in[7];
            end
            if (we_drive) begin
                drive_select_out <= data_in;
            end
        end
    end

    // ==========================================================
    // Panel timing: twelve values, two of them single bytes
    logic                     we_timing;
    logic [TIMING_VALUES-1:0] lo_we;
    logic [TIMING_VALUES-1:0] hi_we;
    logic [10:0]              tval [TIMING_VALUES];
    logic [4:0]               tslot;

    assign we_timing = param_take && (state_q == LCDCD_TIMING);
    // Byte index past the two pulse widths is moved back two bytes for pairing.
    assign tslot = (idx_q > PW_HORIZ_IDX) ? idx_q - 5'd2 : idx_q;

    genvar g;
    generate
        for (g = 0; g < TIMING_VALUES; g++) begin : g_tv
            assign lo_we[g] = we_timing && (idx_q == PW_VERT_IDX ||
                              idx_q == PW_HORIZ_IDX
                              ? idx_q == PW_VERT_IDX + 5'(g - 6)
                                && (g == 6 || g == 7)
                              : (g != 6 && g != 7) && tslot[0] == 1'b0
                                && tslot[4:1] == 4'(g < 6 ? g : g - 2));
            assign hi_we[g] = we_timing && (g != 6) && (g != 7)
                              && idx_q != PW_VERT_IDX
                              && idx_q != PW_HORIZ_IDX
                              && tslot[0] == 1'b1
                              && tslot[4:1] == 4'(g < 6 ? g : g - 2);
            lcdcd_param_reg u_tv (
                .core_clk_in (core_clk_in),
                .srst_in     (srst_in),
                .lo_we_in    (lo_we[g]),
                .hi_we_in    (hi_we[g]),
                .data_in     (data_in),
                .value_out   (tval[g])
            );
        end
    endgenerate

    assign timing_out = {tval[0], tval[1], tval[2], tval[3], tval[4],
                         tval[5], tval[6][7:0], tval[7][7:0], tval[8],
                         tval[9], tval[10], tval[11]};

    // ==========================================================
    // Palette
    logic [PAL_W-1:0] pal_q [PAL_ENTRIES];
    logic             we_pal;
    assign we_pal = param_take && (state_q == LCDCD_PALETTE);

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < PAL_ENTRIES; i++) begin
                pal_q[i] <= '0;
            end
            palette_we_out  <= 1'b0;
            palette_idx_out <= 4'h0;
        end else begin
            palette_we_out <= we_pal;
            if (we_pal) begin
                pal_q[idx_q[3:0]] <= data_in[5:0];
                palette_idx_out   <= idx_q[3:0];
            end
        end
    end

    generate
        for (g = 0; g < PAL_ENTRIES; g++) begin : g_pal
            assign palette_out[g*PAL_W +: PAL_W] = pal_q[g];
        end
    endgenerate

    // ==========================================================
    // Checks
    sequence s_id_cmd;
        cmd_we_in && data_in == CMD_IDENT;
    endsequence

    chk_depth_store: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_depth && !cmd_we_in |=>
        pixel_depth_out == $past(data_in[1:0]))
        else $error("pixel depth not stored");
    chk_ident_read: assert property (@(posedge core_clk_in)
        disable iff (srst_in)
        s_id_cmd ##1 (param_re_in && !cmd_we_in) |=>
        rd_valid_out && rd_data_out == IDENT_CODE)
        else $error("identification byte not returned");
    chk_synth_len: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_synth && idx_q == 5'd2 && !cmd_we_in |=>
        state_q == LCDCD_IDLE)
        else $error("synth sequence length wrong");
    chk_flags_store: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_flags |=>
        flags_out.upscale_mode == $past(data_in[2]))
        else $error("panel flags misplaced");
    chk_timing_len: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_timing && idx_q == 5'd21 && !cmd_we_in |=>
        state_q == LCDCD_IDLE)
        else $error("timing sequence length wrong");
    chk_pulse_width: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_timing && idx_q == PW_HORIZ_IDX |=>
        timing_out.horiz_pulse_width == $past(data_in))
        else $error("horizontal pulse width misplaced");
    chk_scroll_flag: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_scroll |=>
        scroll_sync_flag_out == $past(data_in[7]))
        else $error("scroll flag not stored");
    chk_pal_index: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_pal |=>
        palette_we_out && palette_idx_out == $past(idx_q[3:0]))
        else $error("palette index wrong");
    chk_drive_store: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_drive |=>
        drive_select_out == $past(data_in))
        else $error("drive select not stored");
    chk_zero_bits: assert property (@(posedge core_clk_in)
        disable iff (srst_in) we_timing && idx_q == 5'd1 |=>
        timing_out.horiz_total[10:8] == $past(data_in[2:0]))
        else $error("zero bits leaked");
endmodule

//--- lcdcd_decoder_test.sv
`timescale 1ns/1ps
module lcdcd_decoder_test;
    import lcdcd_pkg::*;
    localparam logic [7:0] ID = 8'h3C; // Arbitrary value

    logic                         core_clk_in = 1'b0;
    logic                         srst_in     = 1'b1;
    logic                         cmd_we, param_we, param_re;
    logic [7:0]                   data, rd_data_out;
    logic                         rd_valid_out, scroll_sync_flag_out;
    logic [1:0]                   pixel_depth_out;
    lcdcd_synth_s                 synth_out;
    lcdcd_flags_s                 flags_out;
    lcdcd_timing_s                timing_out;
    logic [PAL_ENTRIES*PAL_W-1:0] palette_out;
    logic                         palette_we_out, busy_out;
    logic [3:0]                   palette_idx_out;
    logic [7:0]                   drive_select_out;
    int                           failures    = 0;
    int                           comparisons = 0;

    always #2 core_clk_in = ~core_clk_in;

    lcdcd_host_model u_host (.core_clk_in(core_clk_in),
        .cmd_we_out(cmd_we), .param_we_out(param_we),
        .param_re_out(param_re), .data_out(data));

    lcdcd_decoder #(.IDENT_CODE(ID)) u_dut (.core_clk_in(core_clk_in),
        .srst_in(srst_in), .cmd_we_in(cmd_we), .param_we_in(param_we),
        .param_re_in(param_re), .data_in(data),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .pixel_depth_out(pixel_depth_out), .synth_out(synth_out),
        .flags_out(flags_out), .timing_out(timing_out),
        .scroll_sync_flag_out(scroll_sync_flag_out),
        .palette_out(palette_out), .palette_we_out(palette_we_out),
        .palette_idx_out(palette_idx_out),
        .drive_select_out(drive_select_out), .busy_out(busy_out));

    // ==========================================================
    // Comparison and verdict
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk({rd_valid_out, pixel_depth_out, synth_out, flags_out,
             scroll_sync_flag_out, palette_we_out, palette_idx_out,
             drive_select_out, busy_out}, '0);
        chk(timing_out, '0);
        chk(palette_out, '0);
    endtask

    task automatic t_depth();
        u_host.cmd(CMD_PIXEL_DEPTH);
        u_host.idle();
        chk(busy_out, 1'b1);
        u_host.wr(8'hFE);
        u_host.idle();
        chk(pixel_depth_out, 2'b10);
        chk(busy_out, 1'b0);
    endtask

    task automatic t_ident();
        u_host.cmd(CMD_IDENT);
        u_host.rd();
        u_host.idle();
        chk({rd_valid_out, rd_data_out}, {1'b1, ID});
        u_host.rd();
        u_host.idle();
        chk(rd_valid_out, 1'b0);
    endtask

    task automatic t_synth_flags();
        u_host.cmd(CMD_SYNTH);
        u_host.wr(8'h5A);
        u_host.wr(8'hC3);
        u_host.wr(8'hB4);
        u_host.cmd(CMD_PANEL_FLAGS);
        u_host.wr(8'hAD);
        u_host.idle();
        chk(synth_out, 23'h2D_61B4);
        chk(flags_out, 7'h55);
    endtask

    task automatic t_timing();
        logic [10:0]  v;
        logic [125:0] e;
        e = '0;
        u_host.cmd(CMD_PANEL_TIMING);
        for (int i = 0; i < TIMING_VALUES; i++) begin
            v = 11'(i * 171 + 5);
            u_host.wr(v[7:0]);
            // Values 6 and 7 are the two single-byte pulse widths
            if (i == 6 || i == 7) begin
                e = {e[117:0], v[7:0]};
            end else begin
                u_host.wr({5'h1F, v[10:8]});
                e = {e[114:0], v};
            end
        end
        u_host.idle();
        chk(timing_out, e);
        chk(busy_out, 1'b0);
    endtask

    task automatic t_scroll();
        logic [7:0] b [2] = '{8'hFF, 8'h7F};
        for (int i = 0; i < 2; i++) begin
            u_host.cmd(CMD_SCROLL_SYNC);
            u_host.wr(b[i]);
            u_host.idle();
            chk(scroll_sync_flag_out, b[i][7]);
        end
    endtask

    task automatic t_palette();
        logic [PAL_ENTRIES*PAL_W-1:0] e;
        logic [7:0]                   v;
        logic [4:0]                   pw;
        u_host.cmd(CMD_PALETTE);
        for (int i = 0; i < PAL_ENTRIES; i++) begin
            v = 8'(8'hC0 | ((i * 5 + 3) & 8'h3F));
            e[PAL_W*i +: PAL_W] = v[5:0];
            u_host.wr(v);
            if (i > 0) begin
                pw = {1'b1, 4'(i - 1)};
                chk({palette_we_out, palette_idx_out}, pw);
            end
        end
        u_host.idle();
        chk({palette_we_out, palette_idx_out}, 5'h1F);
        chk(palette_out, e);
    endtask

    task automatic t_drive_abort();
        u_host.cmd(CMD_DRIVE_SELECT);
        u_host.wr(8'hA5);
        u_host.idle();
        chk(drive_select_out, 8'hA5);
        u_host.cmd(CMD_PANEL_TIMING);
        u_host.wr(8'h11);
        u_host.cmd(CMD_DRIVE_SELECT);
        u_host.wr(8'h3C);
        u_host.idle();
        chk({busy_out, drive_select_out}, {1'b0, 8'h3C});
        u_host.wr(8'h99);
        u_host.cmd(8'h66);
        u_host.wr(8'h77);
        u_host.idle();
        chk({busy_out, drive_select_out}, {1'b0, 8'h3C});
    endtask

    // Reset in mid-run clears stored fields and cuts a parameter run
    task automatic t_mid_reset();
        u_host.cmd(CMD_PANEL_TIMING);
        u_host.wr(8'h44);
        u_host.idle();
        srst_in = 1'b1;
        u_host.idle();
        u_host.idle();
        srst_in = 1'b0;
        chk({busy_out, drive_select_out, rd_data_out}, '0);
        chk(timing_out, '0);
        u_host.cmd(CMD_PIXEL_DEPTH);
        u_host.wr(8'h01);
        u_host.idle();
        chk(pixel_depth_out, 2'b01);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge core_clk_in);
        #1;
        srst_in = 1'b0;
        t_reset();
        t_depth();
        t_ident();
        t_synth_flags();
        t_timing();
        t_scroll();
        t_palette();
        t_drive_abort();
        t_mid_reset();
        wrap_up();
    end

    // Whole run is under a hundred cycles; this leaves ample margin
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
endmodule

//--- lcdcd_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side: one strobe a cycle, driven just after the edge
module lcdcd_host_model (
    input  wire logic       core_clk_in,
    output logic            cmd_we_out,
    output logic            param_we_out,
    output logic            param_re_out,
    output logic      [7:0] data_out
);
    initial begin
        cmd_we_out   = 1'b0;
        param_we_out = 1'b0;
        param_re_out = 1'b0;
        data_out     = 8'h00;
    end

    task automatic put(input logic c, input logic p, input logic r,
                       input logic [7:0] d);
        @(posedge core_clk_in);
        #1;
        cmd_we_out   = c;
        param_we_out = p;
        param_re_out = r;
        data_out     = d;
    endtask

    // Released bus shows the inverse so a stale byte is never mistaken
    task automatic idle();
        put(1'b0, 1'b0, 1'b0, ~data_out);
    endtask

    task automatic cmd(input logic [7:0] d);
        put(1'b1, 1'b0, 1'b0, d);
    endtask

    task automatic wr(input logic [7:0] d);
        put(1'b0, 1'b1, 1'b0, d);
    endtask

    // Read strobe issued straight after its command
    task automatic rd();
        put(1'b0, 1'b0, 1'b1, ~data_out);
    endtask
endmodule

//--- lcdcd_param_reg.sv
`timescale 1ns/1ps
// One eleven-bit timing value assembled from a low byte and a high byte.
module lcdcd_param_reg
    import lcdcd_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        srst_in,
    input  wire logic        lo_we_in,
    input  wire logic        hi_we_in,
    input  wire logic [7:0]  data_in,
    output logic      [10:0] value_out
);
    logic [10:0] value_q;

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            value_q <= 11'h000;
        end else if (lo_we_in) begin
            value_q[7:0] <= data_in;
        end else if (hi_we_in) begin
            value_q[10:8] <= data_in[2:0];
        end
    end

    assign value_out = value_q;
endmodule

//--- lcdcd_pkg.sv
// Notes on behaviour
// - Command 0x60 takes one parameter; bits 1-0 select pixel depth.
// - Command 0x61 returns one read byte holding a fixed identification code.
// - Command 0x62 takes three synthesiser parameter bytes; the first two hold nibble fields.
// - Command 0x63 takes one byte of polarity flags and mode bits.
// - Command 0x64 takes 22 bytes; 11-bit values sent low byte first.
// - Timing values arrive in fixed order, two 8-bit pulse widths in middle.
// - Command 0x65 takes one byte; bit 7 is the scroll sync flag.
// - Command 0x67 loads sixteen 6-bit palette entries 0 to 15 in order.
// - Command 0x68 takes one byte of eight output drive select flags.
package lcdcd_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_PIXEL_DEPTH   = 8'h60;
    localparam logic [7:0] CMD_IDENT         = 8'h61;
    localparam logic [7:0] CMD_SYNTH         = 8'h62;
    localparam logic [7:0] CMD_PANEL_FLAGS   = 8'h63;
    localparam logic [7:0] CMD_PANEL_TIMING  = 8'h64;
    localparam logic [7:0] CMD_SCROLL_SYNC   = 8'h65;
    localparam logic [7:0] CMD_PALETTE       = 8'h67;
    localparam logic [7:0] CMD_DRIVE_SELECT  = 8'h68;

    // ==========================================================
    // Parameter counts and reset values
    localparam logic [4:0] SYNTH_PARAMS   = 5'd3;
    localparam logic [4:0] TIMING_PARAMS  = 5'd22;
    localparam logic [4:0] PALETTE_PARAMS = 5'd16;
    localparam int         TIMING_VALUES  = 12;
    localparam logic [4:0] PW_VERT_IDX    = 5'd12;
    localparam logic [4:0] PW_HORIZ_IDX   = 5'd13;
    localparam int         PAL_ENTRIES    = 16;
    localparam int         PAL_W          = 6;
    localparam logic [7:0] DRIVE_RESET    = 8'h00;

    typedef enum logic [2:0] {
        LCDCD_IDLE    = 3'b000,
        LCDCD_DEPTH   = 3'b001,
        LCDCD_SYNTH   = 3'b010,
        LCDCD_FLAGS   = 3'b011,
        LCDCD_TIMING  = 3'b100,
        LCDCD_SCROLL  = 3'b101,
        LCDCD_PALETTE = 3'b110,
        LCDCD_DRIVE   = 3'b111
    } lcdcd_state_e;

    typedef struct packed {
        logic [3:0] output_divider;
        logic [3:0] synth_input_divider;
        logic [3:0] synth_range_field;
        logic [3:0] multiplier;
        logic [1:0] two_bit_field;
        logic [4:0] synth_five_bit_field;
    } lcdcd_synth_s;

    typedef struct packed {
        logic vsync_polarity;
        logic hsync_polarity;
        logic data_enable_polarity;
        logic shift_clock_polarity;
        logic upscale_mode;
        logic color_mode_select;
        logic line_option_select;
    } lcdcd_flags_s;

    typedef struct packed {
        logic [10:0] horiz_total;
        logic [10:0] horiz_display_width;
        logic [10:0] horiz_display_start;
        logic [10:0] vert_total;
        logic [10:0] vert_display_height;
        logic [10:0] vert_display_start;
        logic [7:0]  vert_pulse_width;
        logic [7:0]  horiz_pulse_width;
        logic [10:0] horiz_pulse_position;
        logic [10:0] horiz_ratio;
        logic [10:0] vert_ratio;
        logic [10:0] horiz_offset;
    } lcdcd_timing_s;

endpackage
